//--- rtl/serial_link_error_irq_sync_mask.sv
// Purpose: Lane error flags, interrupt masking and sync request generation.
// Assumes: Register port is the internal side of the serial control port.
// Notes:   Interrupt and sync request outputs are active low and registered.
`timescale 1ns/1ps
module serial_link_error_irq_sync_mask
   import lane_error_pkg::*;
#(
   parameter int LANES     = 8,
   parameter int CFG_BYTES = 14
) (
   input  wire logic                   core_clk_i,
   input  wire logic                   nrst_i,
   input  wire reg_addr_t              reg_addr_i,
   input  wire reg_byte_t              reg_wdata_i,
   input  wire logic                   reg_we_i,
   input  wire logic                   reg_re_i,
   output reg_byte_t                   reg_rdata_o,
   input  wire logic [LANES-1:0]       disparity_err_i,
   input  wire logic [LANES-1:0]       invalid_symbol_err_i,
   input  wire logic [LANES-1:0]       stray_control_err_i,
   input  wire logic                   err_count_clear_i,
   input  wire logic [LANES-1:0]       checksum_err_i,
   input  wire logic [LANES-1:0]       symbol_lock_fail_i,
   input  wire logic [CFG_BYTES*8-1:0] rx_config_i,
   input  wire logic [CFG_BYTES*8-1:0] tx_config_i,
   output logic                        irq_n_o,
   output logic                        sync_request_out_n_o
);
`include "lane_error_params.svh"

   // ==========================================================================
   // Registers
   reg_byte_t        irq_mask_q;
   reg_byte_t        sync_en_q;
   reg_byte_t        lane_error_threshold_q;
   reg_byte_t        lane_enable_q;
   logic             config_mismatch_latched_q;
   reg_byte_t        flags_q;
   reg_byte_t        reg_rdata_q;
   logic             irq_n_q;
   logic             sync_request_out_n_q;

   // ==========================================================================
   // Internal signals
   logic [LANES-1:0] lane_en;
   logic [LANES-1:0] disparity_reached;
   logic [LANES-1:0] invalid_symbol_reached;
   logic [LANES-1:0] stray_control_reached;
   reg_byte_t        flags_d;
   logic             mismatch_rise;
   logic             mismatch_clear;
   logic             config_mismatch_irq_en;
   logic             irq_d;
   logic             sync_d;
   reg_byte_t        rdata_d;
   logic             vec_hit;
   logic             sync_hit;
   logic             thr_hit;
   logic             lane_hit;
   logic             disparity_any;
   logic             invalid_symbol_any;
   logic             stray_control_any;
   logic             checksum_any;
   logic             symbol_lock_any;
   logic             irq_flag_cause;
   logic             irq_mismatch_cause;
   logic             sync_disparity;
   logic             sync_invalid_symbol;
   logic             sync_stray_control;
   reg_byte_t        sync_readback;

   mismatch_if #(.CFG_BYTES(CFG_BYTES)) mm ();

   // ==========================================================================
   // Write decode
   // Each register has its own hit so that one strobe never updates two bytes.
   assign lane_en  = lane_enable_q[LANES-1:0];
   assign vec_hit  = reg_we_i && (reg_addr_i == `IRQ_VECTOR_ADDR);
   assign sync_hit = reg_we_i && (reg_addr_i == `SYNC_ENABLES_ADDR);
   assign thr_hit  = reg_we_i && (reg_addr_i == `THRESHOLD_ADDR);
   assign lane_hit = reg_we_i && (reg_addr_i == `LANE_ENABLE_ADDR);

   // ==========================================================================
   // Software writable registers
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_mask_q <= `IRQ_MASK_RESET;
      end else if (vec_hit) begin
         irq_mask_q <= reg_wdata_i;
      end
   end

   // Bit 4 of this register is the latch, kept separately; only bits 7:5 and 3 store here.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_en_q <= `SYNC_ENABLES_RESET;
      end else if (sync_hit) begin
         sync_en_q <= reg_wdata_i & 8'he8;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lane_error_threshold_q <= `THRESHOLD_RESET;
      end else if (thr_hit) begin
         lane_error_threshold_q <= reg_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lane_enable_q <= `LANE_ENABLE_RESET;
      end else if (lane_hit) begin
         lane_enable_q <= reg_wdata_i;
      end
   end

   // ==========================================================================
   // Per-lane error counters
   // Disparity, invalid symbol and stray control errors on every lane keep their own count; all share one threshold.
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         lane_error_counter u_disparity (
            .core_clk_i  (core_clk_i),
            .nrst_i      (nrst_i),
            .err_i       (disparity_err_i[g] & lane_en[g]),
            .clear_i     (err_count_clear_i),
            .threshold_i (lane_error_threshold_q),
            .reached_o   (disparity_reached[g])
         );
         lane_error_counter u_invalid_symbol (
            .core_clk_i  (core_clk_i),
            .nrst_i      (nrst_i),
            .err_i       (invalid_symbol_err_i[g] & lane_en[g]),
            .clear_i     (err_count_clear_i),
            .threshold_i (lane_error_threshold_q),
            .reached_o   (invalid_symbol_reached[g])
         );
         lane_error_counter u_stray_control (
            .core_clk_i  (core_clk_i),
            .nrst_i      (nrst_i),
            .err_i       (stray_control_err_i[g] & lane_en[g]),
            .clear_i     (err_count_clear_i),
            .threshold_i (lane_error_threshold_q),
            .reached_o   (stray_control_reached[g])
         );
      end
   endgenerate

   // ==========================================================================
   // Configuration mismatch
   assign mm.rx_cfg = rx_config_i;
   assign mm.tx_cfg = tx_config_i;

   config_mismatch_detect u_mismatch (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .mm         (mm.detector)
   );

   assign mismatch_rise          = mm.mismatch_rise;
   assign config_mismatch_irq_en = sync_en_q[`SYNC_MISMATCH_EN_BIT];
   assign mismatch_clear         = sync_hit && reg_wdata_i[`SYNC_MISMATCH_BIT];

   // A rise in the same cycle as the clearing write wins, so no mismatch is lost.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         config_mismatch_latched_q <= 1'b0;
      end else if (!config_mismatch_irq_en) begin
         config_mismatch_latched_q <= 1'b0;
      end else if (mismatch_rise) begin
         config_mismatch_latched_q <= 1'b1;
      end else if (mismatch_clear) begin
         config_mismatch_latched_q <= 1'b0;
      end
   end

   // ==========================================================================
   // Lane summaries
   // A lane disabled after it reached the threshold drops out of its flag at once.
   assign disparity_any      = |(disparity_reached & lane_en);
   assign invalid_symbol_any = |(invalid_symbol_reached & lane_en);
   assign stray_control_any  = |(stray_control_reached & lane_en);
   assign checksum_any       = |(checksum_err_i & lane_en);
   assign symbol_lock_any    = |(symbol_lock_fail_i & lane_en);

   // ==========================================================================
   // Flags
   always_comb begin
      flags_d                         = 8'h00;
      flags_d[`IRQ_DISPARITY_BIT]     = disparity_any;
      flags_d[`IRQ_INVALID_SYM_BIT]   = invalid_symbol_any;
      flags_d[`IRQ_STRAY_CTRL_BIT]    = stray_control_any;
      flags_d[`IRQ_CHECKSUM_BIT]      = checksum_any;
      flags_d[`IRQ_SYMBOL_LOCK_BIT]   = symbol_lock_any;
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flags_q <= 8'h00;
      end else begin
         flags_q <= flags_d;
      end
   end

   // ==========================================================================
   // Interrupt output
   // Flags are levels: the line releases when the lane recovers, or for counted errors on a count clear, a higher threshold or a disabled lane.
   assign irq_flag_cause     = |(flags_q & irq_mask_q);
   assign irq_mismatch_cause = config_mismatch_latched_q & config_mismatch_irq_en;

   always_comb begin
      irq_d = irq_flag_cause | irq_mismatch_cause;
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= ~irq_d;
      end
   end

   // ==========================================================================
   // Sync request output
   // Each cause needs its own enable; the mismatch latch never requests a sync.
   assign sync_disparity      = sync_en_q[`SYNC_DISPARITY_BIT]
                                & flags_q[`IRQ_DISPARITY_BIT];
   assign sync_invalid_symbol = sync_en_q[`SYNC_INVALID_SYM_BIT]
                                & flags_q[`IRQ_INVALID_SYM_BIT];
   assign sync_stray_control  = sync_en_q[`SYNC_STRAY_CTRL_BIT]
                                & flags_q[`IRQ_STRAY_CTRL_BIT];

   always_comb begin
      sync_d = sync_disparity | sync_invalid_symbol | sync_stray_control;
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_request_out_n_q <= 1'b1;
      end else begin
         sync_request_out_n_q <= ~sync_d;
      end
   end

   // ==========================================================================
   // Read back
   // Bit 4 reads the live latch, not the stored byte, so a clear shows at once.
   always_comb begin
      sync_readback                     = sync_en_q;
      sync_readback[`SYNC_MISMATCH_BIT] = config_mismatch_latched_q;
   end

   always_comb begin
      rdata_d = 8'h00;
      unique case (reg_addr_i)
         `IRQ_VECTOR_ADDR: begin
            rdata_d = flags_q;
         end
         `SYNC_ENABLES_ADDR: begin
            rdata_d = sync_readback;
         end
         `THRESHOLD_ADDR: begin
            rdata_d = lane_error_threshold_q;
         end
         `LANE_ENABLE_ADDR: begin
            rdata_d = lane_enable_q;
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   // Read data holds between reads, so software may collect it late.
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_q <= 8'h00;
      end else if (reg_re_i) begin
         reg_rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o          = reg_rdata_q;
   assign irq_n_o              = irq_n_q;
   assign sync_request_out_n_o = sync_request_out_n_q;

endmodule : serial_link_error_irq_sync_mask

//--- rtl/lane_error_params.svh
// Purpose: Offsets, field positions, reset values and count limit of the lane error block.
// Assumes: Byte-wide registers reached by their twelve-bit address.
// Notes:   Definitions only.
`ifndef LANE_ERROR_PARAMS_SVH
`define LANE_ERROR_PARAMS_SVH

// ==========================================================================
// Register offsets
`define IRQ_VECTOR_ADDR        12'h47a
`define SYNC_ENABLES_ADDR      12'h47b
`define THRESHOLD_ADDR         12'h47c
`define LANE_ENABLE_ADDR       12'h47d

// ==========================================================================
// Interrupt vector fields
`define IRQ_DISPARITY_BIT      7
`define IRQ_INVALID_SYM_BIT    6
`define IRQ_STRAY_CTRL_BIT     5
`define IRQ_CHECKSUM_BIT       2
`define IRQ_SYMBOL_LOCK_BIT    0

// ==========================================================================
// Sync request enable fields
`define SYNC_DISPARITY_BIT     7
`define SYNC_INVALID_SYM_BIT   6
`define SYNC_STRAY_CTRL_BIT    5
`define SYNC_MISMATCH_BIT      4
`define SYNC_MISMATCH_EN_BIT   3

// ==========================================================================
// Reset values and count limit
`define IRQ_MASK_RESET         8'h00
`define SYNC_ENABLES_RESET     8'h08
`define THRESHOLD_RESET        8'hff
`define LANE_ENABLE_RESET      8'h0f
`define COUNT_MAX              8'hff

`endif

//--- rtl/lane_error_pkg.sv
// Purpose: Shared types of the lane error block.
// Assumes: Nothing beyond the parameter header.
// Notes:   Widths of register bytes and counts are fixed at eight bits.
package lane_error_pkg;

   // =======================================================================
   // Types
   typedef logic [7:0]  reg_byte_t;
   typedef logic [11:0] reg_addr_t;
   typedef logic [7:0]  err_count_t;

endpackage : lane_error_pkg

//--- rtl/mismatch_if.sv
// Purpose: Carries link configuration bytes to the mismatch detector and its edge back.
// Assumes: Both ends run on the same core clock.
// Notes:   No clocking block; plain wires only.
`timescale 1ns/1ps
interface mismatch_if #(
   parameter int CFG_BYTES = 14
);
   logic [CFG_BYTES*8-1:0] rx_cfg;
   logic [CFG_BYTES*8-1:0] tx_cfg;
   logic                   mismatch_rise;

   modport owner    (output rx_cfg, output tx_cfg, input mismatch_rise);
   modport detector (input rx_cfg, input tx_cfg, output mismatch_rise);
endinterface : mismatch_if

//--- rtl/lane_error_counter.sv
// Purpose: Saturating count of one kind of lane error against a threshold.
// Assumes: err_i is one pulse per error event.
// Notes:   Saturation keeps a flooded lane from wrapping below the threshold.
`timescale 1ns/1ps
module lane_error_counter
   import lane_error_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       err_i,
   input  wire logic       clear_i,
   input  wire err_count_t threshold_i,
   output logic            reached_o
);
`include "lane_error_params.svh"

   err_count_t count_q;

   // ==========================================================================
   // Counter
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count_q <= 8'h00;
      end else if (clear_i) begin
         count_q <= 8'h00;
      end else if (err_i && count_q != `COUNT_MAX) begin
         count_q <= count_q + 8'h01;
      end
   end

   assign reached_o = (count_q >= threshold_i);

endmodule : lane_error_counter

//--- rtl/config_mismatch_detect.sv
// Purpose: Compares received lane 0 configuration with local settings, flags rising edges.
// Assumes: Configuration bytes are stable inputs in the core clock domain.
// Notes:   The previous state resets to matching, so a mismatch present at reset rises once.
`timescale 1ns/1ps
module config_mismatch_detect
   import lane_error_pkg::*;
(
   input  wire logic  core_clk_i,
   input  wire logic  nrst_i,
   mismatch_if.detector mm
);
   logic mismatch_d;
   logic mismatch_q;

   // ==========================================================================
   // Compare and edge
   assign mismatch_d = (mm.rx_cfg != mm.tx_cfg);

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mismatch_q <= 1'b0;
      end else begin
         mismatch_q <= mismatch_d;
      end
   end

   assign mm.mismatch_rise = mismatch_d & ~mismatch_q;

endmodule : config_mismatch_detect

//--- sim/link_tx_model.sv
// Purpose: Far side stand-in that emits one-cycle lane error events.
// Assumes: Requests change just after a rising edge.
// Notes:   Registered, so each sampled request gives exactly one pulse.
`timescale 1ns/1ps
module link_tx_model (
   input  wire logic       core_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       fire_i,
   input  wire logic [1:0] kind_i,
   input  wire logic [2:0] lane_i,
   output logic [7:0]      disparity_o,
   output logic [7:0]      invalid_o,
   output logic [7:0]      stray_o
);
   logic [23:0] ev_q;
   // ========
   // Event pulses
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ev_q <= 24'h000000;
      end else begin
         ev_q <= fire_i ? 24'h000001 << (8 * kind_i + lane_i) : 24'h000000;
      end
   end
   assign {stray_o, invalid_o, disparity_o} = ev_q;
endmodule : link_tx_model

//--- sim/serial_link_error_irq_sync_mask_asserts.sv
// Purpose: Port-level checks of flags, interrupt and sync request.
// Assumes: Register writes are seen on the same ports the block uses.
// Notes:   Shadow registers mirror masks, enables and lane enables.
`timescale 1ns/1ps
module serial_link_error_irq_sync_mask_asserts
   import lane_error_pkg::*;
#(
   parameter int LANES     = 8,
   parameter int CFG_BYTES = 14
) (
   input wire logic                   core_clk_i,
   input wire logic                   nrst_i,
   input wire reg_addr_t              reg_addr_i,
   input wire reg_byte_t              reg_wdata_i,
   input wire logic                   reg_we_i,
   input wire logic                   reg_re_i,
   input wire reg_byte_t              reg_rdata_o,
   input wire logic [LANES-1:0]       checksum_err_i,
   input wire logic [LANES-1:0]       symbol_lock_fail_i,
   input wire logic [CFG_BYTES*8-1:0] rx_config_i,
   input wire logic [CFG_BYTES*8-1:0] tx_config_i,
   input wire logic                   irq_n_o,
   input wire logic                   sync_request_out_n_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // ========
   // Shadow registers
   reg_byte_t mask_q, sen_q, lane_q;
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         mask_q <= 8'h00;
         sen_q  <= 8'h08;
         lane_q <= 8'h0f;
      end else if (reg_we_i) begin
         if (reg_addr_i == 12'h47a) mask_q <= reg_wdata_i;
         if (reg_addr_i == 12'h47b) sen_q <= reg_wdata_i;
         if (reg_addr_i == 12'h47d) lane_q <= reg_wdata_i;
      end
   end
   wire cks = |(checksum_err_i & lane_q[LANES-1:0]);
   wire lck = |(symbol_lock_fail_i & lane_q[LANES-1:0]);
   wire sen = |sen_q[7:5];
   wire mme = sen_q[3];
   wire mm  = rx_config_i != tx_config_i;
   wire rdv = reg_re_i && reg_addr_i == 12'h47a;
   // ========
   // Properties
   property p_chk_irq;
      mask_q[2] && cks ##1 mask_q[2] |=> !irq_n_o;
   endproperty
   a_chk_irq: assert property (p_chk_irq) else $error("checksum irq missing");
   property p_chk_flag;
      rdv |=> reg_rdata_o[2] == $past(cks, 2);
   endproperty
   a_chk_flag: assert property (p_chk_flag) else $error("checksum flag wrong");
   property p_lock_flag;
      rdv |=> reg_rdata_o[0] == $past(lck, 2);
   endproperty
   a_lock_flag: assert property (p_lock_flag) else $error("lock flag wrong");
   property p_lock_irq;
      mask_q[0] && lck ##1 mask_q[0] |=> !irq_n_o;
   endproperty
   a_lock_irq: assert property (p_lock_irq) else $error("lock irq missing");
   property p_sync_cause;
      $fell(sync_request_out_n_o) |-> $past(sen) || $past(sen, 2);
   endproperty
   a_sync_cause: assert property (p_sync_cause) else $error("sync not enabled");
   property p_mm_latch;
      mme && $rose(mm) |=> ##1 !irq_n_o;
   endproperty
   a_mm_latch: assert property (p_mm_latch) else $error("mismatch irq missing");
   property p_mm_clear;
      reg_we_i && reg_addr_i == 12'h47b && reg_wdata_i[4] && !$rose(mm) && mask_q == 8'h00
         |=> ##1 irq_n_o;
   endproperty
   a_mm_clear: assert property (p_mm_clear) else $error("mismatch not cleared");
   property p_mm_inert;
      reg_re_i && reg_addr_i == 12'h47b && !mme && !$past(mme) |=> !reg_rdata_o[4];
   endproperty
   a_mm_inert: assert property (p_mm_inert) else $error("mismatch bit active");
   c_sync: cover property ($fell(sync_request_out_n_o));
   c_irq: cover property ($fell(irq_n_o));
   c_mm: cover property (mme && $rose(mm));
endmodule : serial_link_error_irq_sync_mask_asserts

bind serial_link_error_irq_sync_mask serial_link_error_irq_sync_mask_asserts #(
   .LANES(LANES), .CFG_BYTES(CFG_BYTES)) u_chk (.core_clk_i, .nrst_i, .reg_addr_i,
   .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .checksum_err_i, .symbol_lock_fail_i,
   .rx_config_i, .tx_config_i, .irq_n_o, .sync_request_out_n_o);

//--- sim/serial_link_error_irq_sync_mask_bench.sv
// Purpose: Self-checking bench for flags, masks, sync requests and mismatch.
// Assumes: Default of eight lanes, lanes 0 to 3 enabled.
// Notes:   Random lanes, thresholds and bytes come from a fixed seed.
`timescale 1ns/1ps
module serial_link_error_irq_sync_mask_bench
   import lane_error_pkg::*;
;
   logic         clk = 1'b0;
   logic         nrst, we, re, clr, fire, irq_n, sync_n;
   reg_addr_t    addr;
   reg_byte_t    wdata, rdata;
   logic [1:0]   kind;
   logic [2:0]   lane;
   logic [7:0]   cks, lock, disp, inv, stray;
   logic [111:0] rxc, txc;
   int           failures = 0;
   int           compares = 0;
   int           thr, ln, b;
   reg_addr_t    ta[6] = '{12'h47a, 12'h47b, 12'h47c, 12'h47d, 12'h479, 12'h47e};
   reg_byte_t    te[6] = '{8'h00, 8'h08, 8'hff, 8'h0f, 8'h00, 8'h00};
   always #50 clk = ~clk;
   serial_link_error_irq_sync_mask dut (.core_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
      .disparity_err_i(disp), .invalid_symbol_err_i(inv), .stray_control_err_i(stray),
      .err_count_clear_i(clr), .checksum_err_i(cks), .symbol_lock_fail_i(lock),
      .rx_config_i(rxc), .tx_config_i(txc), .irq_n_o(irq_n), .sync_request_out_n_o(sync_n));
   link_tx_model far (.core_clk_i(clk), .nrst_i(nrst), .fire_i(fire), .kind_i(kind),
      .lane_i(lane), .disparity_o(disp), .invalid_o(inv), .stray_o(stray));
   // ========
   // Helpers
   function automatic reg_byte_t bitof(input int k);
      return 8'h80 >> k;
   endfunction : bitof
   task automatic chk(input reg_byte_t got, input reg_byte_t exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : cyc
   task automatic wr(input reg_addr_t a, input reg_byte_t d);
      @(posedge clk) begin addr <= a; wdata <= d; we <= 1'b1; end
      @(posedge clk) we <= 1'b0;
   endtask : wr
   task automatic rd(input reg_addr_t a, input reg_byte_t e);
      @(posedge clk) begin addr <= a; re <= 1'b1; end
      @(posedge clk) re <= 1'b0;
      @(negedge clk) chk(rdata, e);
   endtask : rd
   task automatic lv(input int k, input logic [7:0] v);
      @(posedge clk) if (k == 1) lock <= v; else cks <= v;
   endtask : lv
   task automatic pulses(input int k, input int n);
      if (n > 0) begin
         @(posedge clk) begin fire <= 1'b1; kind <= 2'(k); lane <= 3'(ln); end
         repeat (n) @(posedge clk);
         fire <= 1'b0;
      end
   endtask : pulses
   task automatic print_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   // ========
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #1000000;
      failures++;
      print_verdict();
   end
   // ========
   // Tests
   initial begin
      {nrst, we, re, clr, fire, kind, lane, cks, lock, addr, wdata} = '0;
      void'($urandom(32'h8dd0c46e));
      txc = 112'({$urandom, $urandom, $urandom, $urandom});
      rxc = txc;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      wr(12'h47e, 8'h5a);
      for (int i = 0; i < 6; i++) rd(ta[i], te[i]);
      wr(12'h47b, 8'hff);
      rd(12'h47b, 8'he8);
      for (int k = 0; k < 2; k++) begin
         ln = $urandom_range(3, 0);
         b = (k == 1) ? 1 : 4;
         lv(k, 8'h10 << ln);
         rd(12'h47a, 8'h00);
         lv(k, 8'h01 << ln);
         rd(12'h47a, 8'(b));
         chk({7'h00, irq_n}, 8'h01);
         wr(12'h47a, 8'(b));
         cyc(2);
         chk({7'h00, irq_n}, 8'h00);
         lv(k, 8'h00);
         cyc(2);
         chk({7'h00, irq_n}, 8'h01);
         wr(12'h47a, 8'h00);
      end
      for (int k = 0; k < 3; k++) begin
         thr = $urandom_range(4, 1);
         ln = $urandom_range(3, 0);
         wr(12'h47c, 8'(thr));
         rd(12'h47c, 8'(thr));
         wr(12'h47b, 8'h08 | bitof(k));
         pulses(k, thr - 1);
         cyc(4);
         chk({7'h00, sync_n}, 8'h01);
         pulses(k, 1);
         cyc(4);
         chk({7'h00, sync_n}, 8'h00);
         rd(12'h47a, bitof(k));
         @(posedge clk) clr <= 1'b1;
         @(posedge clk) clr <= 1'b0;
         cyc(3);
         chk({7'h00, sync_n}, 8'h01);
      end
      wr(12'h47c, 8'hff);
      wr(12'h47b, 8'h88);
      pulses(0, 260);
      cyc(4);
      chk({7'h00, sync_n}, 8'h00);
      b = $urandom_range(13, 0);
      wr(12'h47b, 8'h08);
      @(posedge clk) rxc <= txc ^ (112'hff << (8 * b));
      cyc(3);
      chk({7'h00, irq_n}, 8'h00);
      rd(12'h47b, 8'h18);
      wr(12'h47b, 8'h18);
      cyc(2);
      chk({7'h00, irq_n}, 8'h01);
      rd(12'h47b, 8'h08);
      wr(12'h47b, 8'h00);
      @(posedge clk) rxc <= txc;
      @(posedge clk) rxc <= txc ^ (112'hff << (8 * b));
      cyc(3);
      chk({7'h00, irq_n}, 8'h01);
      rd(12'h47b, 8'h00);
      wr(12'h47d, 8'hf0);
      rd(12'h47d, 8'hf0);
      lv(0, 8'h01);
      rd(12'h47a, 8'h00);
      lv(0, 8'h10);
      rd(12'h47a, 8'h04);
      print_verdict();
   end
endmodule : serial_link_error_irq_sync_mask_bench
